// file: osc32k_irq_pkg.sv
package osc32k_irq_pkg;
  localparam logic [11:0] irq_enable_clear_off = 12'h000;
  localparam logic [11:0] irq_enable_set_off = 12'h004;
  localparam logic [11:0] irq_flag_off = 12'h008;
  localparam int osc_ready_bit = 0;
  localparam int clock_failure_bit = 2;
  localparam logic [2:0] enable_mask = 3'h5;
  localparam logic [2:0] enable_reset = 3'h0;
  localparam logic [2:0] flag_reset = 3'h0;
endpackage

// file: osc32k_apb_decode.sv
module osc32k_apb_decode (
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  output logic wr_clear,
  output logic wr_set,
  output logic wr_flag,
  output logic mapped
);
  logic wr;
  assign wr = psel & penable & pwrite;
  assign wr_clear = wr & (paddr == osc32k_irq_pkg::irq_enable_clear_off);
  assign wr_set = wr & (paddr == osc32k_irq_pkg::irq_enable_set_off);
  assign wr_flag = wr & (paddr == osc32k_irq_pkg::irq_flag_off);
  assign mapped = (paddr == osc32k_irq_pkg::irq_enable_clear_off) |
                  (paddr == osc32k_irq_pkg::irq_enable_set_off) |
                  (paddr == osc32k_irq_pkg::irq_flag_off);
endmodule

// file: osc32k_irq_enable_clear.sv
module osc32k_irq_enable_clear (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clock_failure_event,
  input wire logic osc_ready_event,
  output logic irq
);
  logic [2:0] enable_reg, enable_next;
  logic [2:0] flag_reg, flag_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [2:0] event_vec;
  logic wr_clear, wr_set, wr_flag, mapped;
  logic rd_setup;
  logic [2:0] pending;

  // one place decides which offsets show the shared enable store
  function automatic logic shows_enables(input logic [11:0] addr);
    return (addr == osc32k_irq_pkg::irq_enable_clear_off) ||
           (addr == osc32k_irq_pkg::irq_enable_set_off);
  endfunction

  function automatic logic shows_flags(input logic [11:0] addr);
    return addr == osc32k_irq_pkg::irq_flag_off;
  endfunction

  // only the two enable positions can ever hold a one
  function automatic logic [2:0] live_bits(input logic [31:0] data);
    return data[2:0] & osc32k_irq_pkg::enable_mask;
  endfunction

  osc32k_apb_decode u_decode (
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .wr_clear(wr_clear),
    .wr_set(wr_set),
    .wr_flag(wr_flag),
    .mapped(mapped)
  );

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_reg;
  assign rd_setup = psel & ~penable & ~pwrite;

  always_comb begin
    event_vec = 3'h0;
    event_vec[osc32k_irq_pkg::clock_failure_bit] = clock_failure_event;
    event_vec[osc32k_irq_pkg::osc_ready_bit] = osc_ready_event;
  end

  // one enable store serves both views; zeros in pwdata leave bits alone
  always_comb begin
    enable_next = enable_reg;
    if (wr_clear) begin
      enable_next = enable_reg & ~live_bits(pwdata);
    end
    if (wr_set) begin
      enable_next = enable_reg | live_bits(pwdata);
    end
  end

  // an event in the same cycle as its write-one clear wins
  always_comb begin
    flag_next = flag_reg;
    if (wr_flag) begin
      flag_next = flag_reg & ~live_bits(pwdata);
    end
    flag_next = flag_next | event_vec;
  end

  // read data registered during setup so it is stable for the access phase
  always_comb begin
    prdata_next = prdata_reg;
    if (rd_setup) begin
      prdata_next = 32'h00000000;
      if (shows_enables(paddr)) begin
        prdata_next[2:0] = enable_reg;
      end else if (shows_flags(paddr)) begin
        prdata_next[2:0] = flag_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= osc32k_irq_pkg::enable_reset;
    end else begin
      enable_reg <= enable_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= osc32k_irq_pkg::flag_reset;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // read data stays zero after reset until the first read setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // per-bit request, so a bit that can never be enabled cannot raise irq
  for (genvar gi = 0; gi < 3; gi++) begin : g_pending
    assign pending[gi] = enable_reg[gi] & flag_reg[gi];
  end

  assign irq = |pending;

  property p_clear_bit(int b);
    @(posedge pclk) disable iff (!presetn)
    (wr_clear && pwdata[b] && !wr_set) |=> !enable_reg[b];
  endproperty
  chk_fail_clear: assert property (p_clear_bit(2)) else $error("clock failure enable not cleared");
  chk_ready_clear: assert property (p_clear_bit(0)) else $error("ready enable not cleared");
  chk_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_clear && pwdata[2:0] == 3'h0) |=> $stable(enable_reg))
    else $error("zero write changed enables");
  chk_set_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_set && pwdata[2]) |=> enable_reg[2])
    else $error("set write did not set enable");
  sequence s_set_read;
    wr_set && pwdata[0] ##[1:2] psel && !penable && !pwrite &&
      paddr == osc32k_irq_pkg::irq_enable_clear_off && !wr_clear;
  endsequence
  chk_shared_view: assert property (@(posedge pclk) disable iff (!presetn)
    s_set_read |=> prdata[0])
    else $error("clear view does not reflect set");
  chk_irq_fail: assert property (@(posedge pclk) disable iff (!presetn)
    (enable_reg[2] && flag_reg[2]) |-> irq)
    else $error("interrupt missing");
  chk_readback: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == osc32k_irq_pkg::irq_enable_set_off)
    |=> prdata[2:0] == $past(enable_reg))
    else $error("enable readback wrong");
  chk_event_wins: assert property (@(posedge pclk) disable iff (!presetn)
    clock_failure_event |=> flag_reg[2])
    else $error("event lost");
  chk_no_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (enable_reg == 3'h0) |-> !irq)
    else $error("irq with no enable");

  for (genvar gb = 0; gb < 3; gb++) begin : g_bit_checks
    if (osc32k_irq_pkg::enable_mask[gb]) begin : g_live
      chk_keep_other: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_clear && !pwdata[gb]) |=> enable_reg[gb] == $past(enable_reg[gb]))
        else $error("clear write touched an unselected enable");
      chk_set_each: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_set && pwdata[gb]) |=> enable_reg[gb])
        else $error("set write missed an enable");
      chk_irq_each: assert property (@(posedge pclk) disable iff (!presetn)
        (enable_reg[gb] && flag_reg[gb]) |-> irq)
        else $error("enabled flag gave no interrupt");
      chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (flag_reg[gb] && !(wr_flag && pwdata[gb])) |=> flag_reg[gb])
        else $error("flag dropped without a clear");
    end else begin : g_dead
      chk_dead_bit: assert property (@(posedge pclk) disable iff (!presetn)
        !enable_reg[gb] && !flag_reg[gb])
        else $error("unused bit position holds a one");
    end
  end

  sequence s_fail_clear_write;
    wr_clear && pwdata[osc32k_irq_pkg::clock_failure_bit];
  endsequence
  sequence s_enable_read;
    rd_setup && shows_enables(paddr);
  endsequence
  chk_clear_visible: assert property (@(posedge pclk) disable iff (!presetn)
    s_fail_clear_write ##[1:2] s_enable_read |=> !prdata[2])
    else $error("cleared enable still reads as set");
  chk_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup |=> (prdata[31:3] == 29'h0 && !prdata[1]))
    else $error("unused read bits not zero");
  chk_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && !mapped) |=> prdata == 32'h00000000)
    else $error("unmapped read returned data");
  chk_unmapped_write: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && !mapped) |=> $stable(enable_reg))
    else $error("unmapped write changed enables");
  chk_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_flag && pwdata[0] && !osc_ready_event) |=> !flag_reg[0])
    else $error("ready flag not cleared");
endmodule

// file: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic pready, pslverr, irq, clock_failure_event = 0, osc_ready_event = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic [2:0] en_m = 3'h0, fl_m = 3'h0;
  int n_fail = 0, checks_done = 0, op;
  always #25 pclk = ~pclk;
  osc32k_irq_enable_clear dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .clock_failure_event, .osc_ready_event, .irq);
  task automatic chk_data(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t read data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(logic got, logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t irq %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_err(logic got, logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t pslverr %b expected %b", $time, got, exp);
    end
  endtask
  // master waits on pready instead of assuming zero wait states
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // an idle edge keeps the next setup from reassigning psel in this step
    @(posedge pclk);
  endtask
  task automatic check_all();
    apb(0, 12'h000, 0);
    chk_data(rd, {29'h0, en_m});
    chk_err(err, 1'b0);
    apb(0, 12'h004, 0);
    chk_data(rd, {29'h0, en_m});
    apb(0, 12'h008, 0);
    chk_data(rd, {29'h0, fl_m});
    chk_irq(irq, |(en_m & fl_m));
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
  initial begin
    void'($urandom(32'hB4029201));
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    check_all();
    $display("test reset done");
    for (int i = 0; i < 80; i++) begin
      v = $urandom;
      op = $urandom % 4;
      case (op)
        0: begin
          apb(1, 12'h000, v);
          en_m &= ~v[2:0];
        end
        1: begin
          apb(1, 12'h004, v);
          en_m |= v[2:0] & 3'h5;
        end
        2: begin
          apb(1, 12'h008, v);
          fl_m &= ~v[2:0];
        end
        default: begin
          clock_failure_event <= v[0];
          osc_ready_event <= v[1];
          @(posedge pclk);
          clock_failure_event <= 0;
          osc_ready_event <= 0;
          fl_m |= {v[0], 1'b0, v[1]};
        end
      endcase
      check_all();
    end
    $display("test random done");
    // an event that meets a write-one clear of its own flag must survive
    clock_failure_event <= 1;
    apb(1, 12'h008, 32'h00000005);
    clock_failure_event <= 0;
    fl_m = 3'h4;
    apb(1, 12'h004, 32'h00000005);
    en_m = 3'h5;
    check_all();
    apb(1, 12'h000, 32'h00000004);
    en_m = 3'h1;
    check_all();
    $display("test event wins done");
    presetn <= 0;
    @(posedge pclk);
    @(posedge pclk);
    presetn <= 1;
    en_m = 3'h0;
    fl_m = 3'h0;
    @(posedge pclk);
    check_all();
    $display("test mid reset done");
    apb(1, 12'h00C, 32'hFFFFFFFF);
    chk_err(err, 1'b1);
    apb(0, 12'h00C, 0);
    chk_data(rd, 32'h0);
    chk_err(err, 1'b1);
    check_all();
    $display("test unmapped done");
    summarize();
  end
endmodule
